/* File: include/lrcf_regs.svh */
/*
  register offsets, reset values, field positions and counts of the link receive clocking block.
  assumes inclusion by bare name from the design file, the peer model and the testbench.
*/
`ifndef LRCF_REGS_SVH
`define LRCF_REGS_SVH
`define LRCF_OFF_RATE   4'h0
`define LRCF_OFF_PEER   4'h4
`define LRCF_OFF_STATUS 4'h8
`define LRCF_OFF_UNIT   4'hc
`define LRCF_RATE_DEF   4'h0
`define LRCF_PEER_DEF   4'h0
`define LRCF_UNIT_DEF   5'h00
`define LRCF_ST_CRC     0
`define LRCF_ST_OVR     1
`define LRCF_ST_UDR     2
`define LRCF_ST_PRIMED  3
`define LRCF_ST_STOP    4
`define LRCF_HP_DEF     4'h8
`define LRCF_HP_MIN     4'h2
`define LRCF_DEPTH      4'h8
`define LRCF_PTR_OFF    4'h2
`define LRCF_CRC_POS    10'd512
`define LRCF_CRC_END    10'd515
`define LRCF_WIN_LAST   10'd511
`define LRCF_SETTLE     4'hf
`define LRCF_CRC_INIT   32'hffffffff
`define LRCF_CRC_POLY   32'h04c11db7
`endif

/* File: include/lrcf_pkg.sv */
/*
  types of the link receive clocking block: clocking modes, register bus request, state record.
  assumes the register header sits beside it.
*/
`default_nettype none
package lrcf_pkg;
  typedef enum logic [3:0] {
    LRCF_MODE_SYNC   = 4'b0001,
    LRCF_MODE_PSEUDO = 4'b0010,
    LRCF_MODE_ASYNC  = 4'b0100,
    LRCF_MODE_ARB    = 4'b1000
  } lrcf_mode_t;

  typedef struct packed {
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } lrcf_bus_t;

  typedef struct packed {
    logic [1:0]            pg_s;
    logic [1:0]            stop_s;
    logic [1:0]            clk_s1;
    logic [1:0]            clk_s2;
    logic [1:0]            clk_q;
    logic [15:0]           cad_s1;
    logic [15:0]           cad_s2;
    logic [1:0][7:0][7:0]  mem;
    logic [1:0][3:0]       wptr;
    logic [3:0]            rptr;
    logic                  primed;
    logic [1:0][9:0]       bitcnt;
    logic [1:0][31:0]      crc_cap;
    logic [1:0]            crc_full;
    logic [1:0][31:0]      crc_calc;
    logic [1:0][31:0]      crc_ref;
    logic [9:0]            rdcnt;
    logic                  chk_pend;
    logic [3:0]            settle;
    logic [3:0]            rate_prog;
    logic [3:0]            rate_act;
    logic [3:0]            peer_max;
    logic [4:0]            unit;
    logic                  crc_err;
    logic                  overrun;
    logic                  underrun;
    logic [3:0]            tx_div;
    logic                  tx_clk;
    logic [4:0]            rd_div;
    logic [15:0]           rx_data;
    logic                  rx_valid;
    logic [31:0]           rdata;
  } lrcf_state_t;
endpackage : lrcf_pkg
`default_nettype wire

/* File: design/lrcf_top.sv */
/*
  receive clocking of one point-to-point link port: rate selection, transmit clock divider,
  sampled two-lane receive fifo, crc bypass and check, cold and warm reset handling.
  assumes a 100 mhz system clock, a slow forwarded link clock per 8-bit lane group sampled
  by that clock, and the plain register port of the host.
*/
// Decided for this implementation: the placing of the registers and the address-and-strobe port.
// Functional notes
// - same-base mode: transmit clock runs exactly at the active link rate
// - receive unload rate and transmit rate come from one rate setting, unless a reduced-rate mode caps transmit at the peer maximum
// - reduced-rate mode: transmit rate capped by peer maximum receive rate
// - independent-base mode: transmit rate derived from local clock, no deviation
// - receiver tolerates a faster incoming clock; overrun is flagged, never silent
// - arbitrary independent mode: transmit rate at most peer maximum rate
// - same-base mode always present; other modes picked by a static input
// - incoming bytes written into fifo on forwarded link clock edges
// - unload waits until both lane groups hold data, absorbing lane skew
// - each lane writes consecutive bit-times into rotating fifo entries
// - pointers cleared together; unload starts at a fixed pointer offset
// - unload pointer frozen when no entry is ready in slower-sender modes
// - crc bit-times go to dedicated flops, fifo write pointer untouched
// - crc recomputed over unloaded stream and compared after settling
// - crc slots give the slip margin against a faster sender
// - cold reset selects the 200 mhz default rate code
// - programmed rate applied only at warm reset or link stop
// - cold reset clears all state except the input sync stages and crc_calc, which loads the crc seed, and clears configuration and unit number
// - warm reset keeps persistent rate setting and crc error log
`timescale 1ns/10ps
`default_nettype none
`include "lrcf_regs.svh"

module lrcf_top (
  input  wire logic                sys_clk_in,
  input  wire logic                rst_b_in,
  input  wire logic                power_good_in,
  input  wire logic                link_stop_n_in,
  input  wire logic [1:0]          link_clk_in,
  input  wire logic [15:0]         link_cad_in,
  input  wire lrcf_pkg::lrcf_mode_t clk_mode_in,
  input  wire lrcf_pkg::lrcf_bus_t bus_in,
  output logic [31:0]              bus_rdata_out,
  output logic                     tx_clk_out,
  output logic [15:0]              rx_data_out,
  output logic                     rx_valid_out,
  output logic [4:0]               node_unit_number_out
);

  lrcf_pkg::lrcf_state_t s;
  lrcf_pkg::lrcf_state_t n;
  lrcf_pkg::lrcf_state_t k;
  logic [1:0]            lane_edge;
  logic [1:0][3:0]       occ;
  logic [3:0]            tx_code;
  logic                  reduced;
  logic                  freeze_ok;
  logic                  rd_tick;
  logic                  chk_go;
  logic                  crc_bad;

  function automatic logic [3:0] lrcf_half(input logic [3:0] c);
    return (c >= (`LRCF_HP_DEF - `LRCF_HP_MIN)) ? `LRCF_HP_MIN : (`LRCF_HP_DEF - c);
  endfunction : lrcf_half

  function automatic logic [31:0] lrcf_crc8(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++)
    begin
      r = {r[30:0], 1'b0} ^ ((r[31] ^ d[i]) ? `LRCF_CRC_POLY : 32'h0);
    end
    return r;
  endfunction : lrcf_crc8

  // the second sync stage and its delayed copy clk_q feed the edge detect
  for (genvar g = 0; g < 2; g++)
  begin : g_lane
    assign lane_edge[g] = s.clk_s2[g] & ~s.clk_q[g];
    assign occ[g]       = s.wptr[g] - s.rptr;
  end

  assign reduced   = (clk_mode_in == lrcf_pkg::LRCF_MODE_PSEUDO) || (clk_mode_in == lrcf_pkg::LRCF_MODE_ARB);
  // local divider has no ppm error, so tolerance limits hold by construction
  assign tx_code   = (reduced && (s.peer_max < s.rate_act)) ? s.peer_max : s.rate_act;
  assign freeze_ok = (clk_mode_in != lrcf_pkg::LRCF_MODE_SYNC);
  assign rd_tick   = (s.rd_div == 5'h00);
  assign chk_go    = s.chk_pend && (&s.crc_full) && (s.settle == 4'h0);
  assign crc_bad   = (s.crc_ref != s.crc_cap);

  always_comb
  begin
    logic ovr_set;
    logic udr_set;
    logic crc_set;
    logic cold;
    ovr_set = 1'b0;
    udr_set = 1'b0;
    crc_set = 1'b0;
    cold    = 1'b0;
    k       = '0;
    n       = s;
    n.pg_s   = {s.pg_s[0], power_good_in};
    n.stop_s = {s.stop_s[0], link_stop_n_in};
    n.clk_s1 = link_clk_in;
    n.clk_s2 = s.clk_s1;
    n.clk_q  = s.clk_s2;
    n.cad_s1 = link_cad_in;
    n.cad_s2 = s.cad_s1;
    n.rx_valid = 1'b0;
    n.rdata    = 32'h0;
    if (s.tx_div == 4'h0)
    begin
      n.tx_div = lrcf_half(tx_code) - 4'h1;
      n.tx_clk = ~s.tx_clk;
    end
    else
    begin
      n.tx_div = s.tx_div - 4'h1;
    end
    if (rd_tick)
    begin
      n.rd_div = {lrcf_half(s.rate_act), 1'b0} - 5'h01;
    end
    else
    begin
      n.rd_div = s.rd_div - 5'h01;
    end
    for (int l = 0; l < 2; l++)
    begin
      if (lane_edge[l])
      begin
        if (s.bitcnt[l] >= `LRCF_CRC_POS)
        begin
          n.crc_cap[l] = {s.crc_cap[l][23:0], s.cad_s2[l*8 +: 8]};
          if (s.bitcnt[l] == `LRCF_CRC_END)
          begin
            n.crc_full[l] = 1'b1;
          end
        end
        else if (occ[l] == `LRCF_DEPTH)
        begin
          ovr_set = 1'b1;
        end
        else
        begin
          n.mem[l][s.wptr[l][2:0]] = s.cad_s2[l*8 +: 8];
          n.wptr[l] = s.wptr[l] + 4'h1;
        end
        // crc slots recur every window, so unload can always catch up
        n.bitcnt[l] = (s.bitcnt[l] == `LRCF_CRC_END) ? 10'd0 : (s.bitcnt[l] + 10'd1);
      end
    end
    if (!s.primed)
    begin
      n.primed = (occ[0] >= `LRCF_PTR_OFF) && (occ[1] >= `LRCF_PTR_OFF);
    end
    else if (rd_tick)
    begin
      if ((occ[0] != 4'h0) && (occ[1] != 4'h0))
      begin
        n.rx_valid = 1'b1;
        n.rx_data  = {s.mem[1][s.rptr[2:0]], s.mem[0][s.rptr[2:0]]};
        n.rptr     = s.rptr + 4'h1;
        for (int l = 0; l < 2; l++)
        begin
          n.crc_calc[l] = lrcf_crc8(s.crc_calc[l], s.mem[l][s.rptr[2:0]]);
        end
        if (s.rdcnt == `LRCF_WIN_LAST)
        begin
          n.rdcnt    = 10'd0;
          n.crc_ref  = n.crc_calc;
          n.crc_calc = {2{`LRCF_CRC_INIT}};
          n.chk_pend = 1'b1;
          n.settle   = `LRCF_SETTLE;
        end
        else
        begin
          n.rdcnt = s.rdcnt + 10'd1;
        end
      end
      else if (!freeze_ok)
      begin
        udr_set = 1'b1;
      end
    end
    // capture flops are read only after the settle wait
    if (s.chk_pend && (&s.crc_full))
    begin
      if (chk_go)
      begin
        crc_set    = crc_bad;
        n.chk_pend = 1'b0;
        n.crc_full = 2'b00;
      end
      else
      begin
        n.settle = s.settle - 4'h1;
      end
    end
    if (bus_in.rd)
    begin
      case (bus_in.addr)
        `LRCF_OFF_RATE:   n.rdata = {24'h0, s.rate_act, s.rate_prog};
        `LRCF_OFF_PEER:   n.rdata = {28'h0, s.peer_max};
        `LRCF_OFF_STATUS: n.rdata = {27'h0, ~s.stop_s[1], s.primed, s.underrun, s.overrun, s.crc_err};
        `LRCF_OFF_UNIT:   n.rdata = {27'h0, s.unit};
        default:          n.rdata = 32'h0;
      endcase
    end
    n.crc_err  = crc_set | s.crc_err;
    n.overrun  = ovr_set | s.overrun;
    n.underrun = udr_set | s.underrun;
    if (bus_in.wr)
    begin
      case (bus_in.addr)
        `LRCF_OFF_RATE: n.rate_prog = bus_in.wdata[3:0];
        `LRCF_OFF_PEER: n.peer_max  = bus_in.wdata[3:0];
        `LRCF_OFF_UNIT: n.unit      = bus_in.wdata[4:0];
        `LRCF_OFF_STATUS:
        begin
          // a flag set in the clearing cycle survives
          n.crc_err  = crc_set | (s.crc_err & ~bus_in.wdata[`LRCF_ST_CRC]);
          n.overrun  = ovr_set | (s.overrun & ~bus_in.wdata[`LRCF_ST_OVR]);
          n.underrun = udr_set | (s.underrun & ~bus_in.wdata[`LRCF_ST_UDR]);
        end
        default: n.unit = s.unit;
      endcase
    end
    if (!s.stop_s[1])
    begin
      n.wptr     = '0;
      n.rptr     = 4'h0;
      n.primed   = 1'b0;
      n.bitcnt   = '0;
      n.rdcnt    = 10'd0;
      n.crc_calc = {2{`LRCF_CRC_INIT}};
      n.crc_full = 2'b00;
      n.chk_pend = 1'b0;
      n.rx_valid = 1'b0;
      n.rate_act = s.rate_prog;
    end
    if (!rst_b_in)
    begin
      cold = ~s.pg_s[1];
      k    = n;
      n    = '0;
      n.pg_s     = k.pg_s;
      n.stop_s   = k.stop_s;
      n.clk_s1   = k.clk_s1;
      n.clk_s2   = k.clk_s2;
      n.clk_q    = k.clk_q;
      n.cad_s1   = k.cad_s1;
      n.cad_s2   = k.cad_s2;
      n.crc_calc = {2{`LRCF_CRC_INIT}};
      n.peer_max = `LRCF_PEER_DEF;
      n.unit     = `LRCF_UNIT_DEF;
      n.rate_prog = cold ? `LRCF_RATE_DEF : s.rate_prog;
      n.rate_act  = cold ? `LRCF_RATE_DEF : s.rate_prog;
      n.crc_err   = cold ? 1'b0 : s.crc_err;
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    s <= n;
  end

  assign bus_rdata_out        = s.rdata;
  assign tx_clk_out           = s.tx_clk;
  assign rx_data_out          = s.rx_data;
  assign rx_valid_out         = s.rx_valid;
  assign node_unit_number_out = s.unit;

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_b_in);

  sequence s_stop;
    !s.stop_s[1];
  endsequence
  sequence s_starve;
    s.primed && rd_tick && s.stop_s[1] && ((occ[0] == 4'h0) || (occ[1] == 4'h0));
  endsequence
  sequence s_read;
    s.primed && rd_tick && s.stop_s[1] && (occ[0] != 4'h0) && (occ[1] != 4'h0);
  endsequence
  sequence s_lane0_data;
    lane_edge[0] && s.stop_s[1] && (s.bitcnt[0] < `LRCF_CRC_POS) && (occ[0] != `LRCF_DEPTH);
  endsequence
  sequence s_lane1_data;
    lane_edge[1] && s.stop_s[1] && (s.bitcnt[1] < `LRCF_CRC_POS) && (occ[1] != `LRCF_DEPTH);
  endsequence
  sequence s_lane1_crc_last;
    lane_edge[1] && s.stop_s[1] && (s.bitcnt[1] == `LRCF_CRC_END);
  endsequence
  // settle wait runs only once both lanes hold a full crc word
  sequence s_settling;
    s.chk_pend && (&s.crc_full) && (s.settle != 4'h0) && s.stop_s[1];
  endsequence
  sequence s_win_last;
    s_read ##0 ((s.rdcnt == `LRCF_WIN_LAST) && !s.chk_pend);
  endsequence

  AST_COLD_RESET: assert property (disable iff (1'b0) (!rst_b_in && !s.pg_s[1]) |=>
    (s.rate_act == `LRCF_RATE_DEF) && (s.rate_prog == `LRCF_RATE_DEF) && !s.crc_err && (s.unit == `LRCF_UNIT_DEF))
    else $error("cold reset left state behind");
  AST_WARM_KEEP: assert property (disable iff (1'b0) (!rst_b_in && s.pg_s[1]) |=>
    (s.rate_prog == $past(s.rate_prog)) && (s.crc_err == $past(s.crc_err)) && (s.rate_act == $past(s.rate_prog)))
    else $error("warm reset lost persistent state");
  AST_RATE_HOLD: assert property (s.stop_s[1] |=> (s.rate_act == $past(s.rate_act)))
    else $error("active rate changed while link runs");
  // checked at every reload outside the reduced-rate modes, so a divider fed from the wrong setting is caught there
  AST_TX_EXACT: assert property ((!reduced && (s.tx_div == 4'h0)) |=>
    (s.tx_div == lrcf_half($past(s.rate_act)) - 4'h1) && (s.tx_clk != $past(s.tx_clk)))
    else $error("transmit rate differs from active rate");
  AST_TX_CAP: assert property ((reduced && (s.tx_div == 4'h0)) |=>
    (s.tx_div >= lrcf_half($past(s.peer_max)) - 4'h1) && (s.tx_div >= lrcf_half($past(s.rate_act)) - 4'h1))
    else $error("transmit rate above peer limit");
  AST_TX_STILL: assert property ((s.tx_div != 4'h0) |=> (s.tx_clk == $past(s.tx_clk)))
    else $error("transmit clock toggled mid half period");
  AST_RD_PERIOD: assert property (rd_tick |=>
    (s.rd_div == {lrcf_half($past(s.rate_act)), 1'b0} - 5'h01))
    else $error("unload tick not paced by active rate");
  AST_INIT_PTR: assert property (s_stop |=> (s.rptr == 4'h0) && (s.wptr == '0) && !s.primed ##1 !s.rx_valid)
    else $error("pointers not initialised on link stop");
  AST_FREEZE: assert property (s_starve ##0 freeze_ok |=> (s.rptr == $past(s.rptr)) && !s.rx_valid)
    else $error("unload pointer moved with no data");
  AST_SYNC_UDR: assert property (s_starve ##0 !freeze_ok |=> s.underrun)
    else $error("same-base starvation not flagged");
  AST_UNLOAD: assert property (s_read |=> s.rx_valid && (s.rptr == $past(s.rptr) + 4'h1) ##1 !s.rx_valid)
    else $error("ready entries not unloaded");
  AST_ROTATE: assert property (s_lane0_data |=> (s.wptr[0] == $past(s.wptr[0]) + 4'h1))
    else $error("lane write pointer did not rotate");
  AST_CRC_BYPASS: assert property ((lane_edge[0] && s.stop_s[1] && (s.bitcnt[0] >= `LRCF_CRC_POS)) |=>
    (s.wptr[0] == $past(s.wptr[0])) && (s.crc_cap[0][7:0] == $past(s.cad_s2[7:0])))
    else $error("crc byte entered the fifo");
  AST_OVERRUN: assert property ((lane_edge[0] && s.stop_s[1] && (s.bitcnt[0] < `LRCF_CRC_POS) &&
    (occ[0] == `LRCF_DEPTH)) |=> s.overrun && (s.wptr[0] == $past(s.wptr[0])))
    else $error("overrun not flagged");
  AST_CRC_CHECK: assert property ((chk_go && crc_bad && s.stop_s[1]) |=> s.crc_err && !s.chk_pend)
    else $error("crc mismatch not logged");
  AST_CRC_PASS: assert property ((chk_go && !crc_bad && s.stop_s[1]) |=>
    !s.chk_pend && (s.crc_full == 2'b00))
    else $error("matching crc check not retired");
  AST_WIN_END: assert property (s_win_last |=> s.chk_pend && (s.rdcnt == 10'd0))
    else $error("crc window end not latched");
  AST_SETTLE: assert property (s_settling |=> s.chk_pend && (s.settle == $past(s.settle) - 4'h1))
    else $error("crc flops read before settling");
  AST_CRC_SLOT1: assert property (s_lane1_crc_last |=> (s.bitcnt[1] == 10'd0) &&
    (s.wptr[1] == $past(s.wptr[1])))
    else $error("lane 1 crc slot mishandled");
  AST_ROTATE1: assert property (s_lane1_data |=> (s.wptr[1] == $past(s.wptr[1]) + 4'h1))
    else $error("lane 1 write pointer did not rotate");
  AST_RX_PAIR: assert property (s_read |=>
    (s.rx_data == {$past(s.mem[1][s.rptr[2:0]]), $past(s.mem[0][s.rptr[2:0]])}))
    else $error("unloaded word does not pair the lanes");

  // unload must not start before the write side is the pointer offset ahead
  AST_NO_EARLY: assert property (!s.primed |=> !s.rx_valid)
    else $error("unload before pointers primed");
  AST_PRIME: assert property ((!s.primed && s.stop_s[1] && (occ[0] >= `LRCF_PTR_OFF) &&
    (occ[1] >= `LRCF_PTR_OFF)) |=> s.primed)
    else $error("fifo not primed at pointer offset");
  AST_STOP_APPLY: assert property (s_stop |=> (s.rate_act == $past(s.rate_prog)))
    else $error("link stop did not apply programmed rate");
  AST_RATE_WR: assert property ((bus_in.wr && (bus_in.addr == `LRCF_OFF_RATE) && s.stop_s[1]) |=>
    (s.rate_prog == $past(bus_in.wdata[3:0])) && (s.rate_act == $past(s.rate_act)))
    else $error("rate write applied at once or lost");
  AST_UNIT_WR: assert property ((bus_in.wr && (bus_in.addr == `LRCF_OFF_UNIT)) |=>
    (s.unit == $past(bus_in.wdata[4:0])))
    else $error("unit number write lost");
  AST_WARM_CLEAR: assert property (disable iff (1'b0) (!rst_b_in && s.pg_s[1]) |=>
    (s.peer_max == `LRCF_PEER_DEF) && (s.unit == `LRCF_UNIT_DEF) && !s.overrun && !s.underrun)
    else $error("warm reset kept volatile state");

endmodule : lrcf_top
`default_nettype wire

/* File: sim/lrcf_peer.sv */
/*
  peer transmitter model: forwarded clock and data per 8-bit lane group, crc bytes after each window.
  assumes a 125 ns bit-time; lane 1 trails lane 0 by 20 ns.
*/
`timescale 1ns/10ps
`default_nettype none
`include "lrcf_regs.svh"
module lrcf_peer (
  output wire logic [1:0]  link_clk_out,
  output wire logic [15:0] link_cad_out
);
  logic       clk0;
  logic [7:0] cad0;
  logic [7:0] cad1;

  // skewed lane group, the receive fifo has to absorb it
  assign link_clk_out[0]        = clk0;
  assign #20 link_clk_out[1]    = clk0;
  assign link_cad_out[7:0]      = cad0;
  assign #20 link_cad_out[15:8] = cad1;

  initial
  begin
    clk0 = 1'b0;
    cad0 = 8'h00;
    cad1 = 8'h00;
  end

  // data word n of the stream, {lane1, lane0}
  function automatic logic [15:0] word(input int n);
    return {n[7:0] ^ 8'ha5 ^ n[15:8], n[7:0] + n[15:8]};
  endfunction : word

  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++)
      r = {r[30:0], 1'b0} ^ ((r[31] ^ d[i]) ? `LRCF_CRC_POLY : 32'h0);
    return r;
  endfunction : crc_byte

  // 512 data bit-times, then 4 crc bit-times, msb byte first
  task send_window(input int base, input logic bad);
    logic [31:0] c0;
    logic [31:0] c1;
    logic [15:0] w;
    c0 = `LRCF_CRC_INIT;
    c1 = `LRCF_CRC_INIT;
    for (int i = 0; i < 516; i++)
    begin
      if (i < 512)
      begin
        w  = word(base + i);
        c0 = crc_byte(c0, w[7:0]);
        c1 = crc_byte(c1, w[15:8]);
      end
      else
        w = {c1[8*(515-i)+:8], c0[8*(515-i)+:8] ^ {7'h00, bad}};
      cad0 = w[7:0];
      cad1 = w[15:8];
      #62.5 clk0 = 1'b1;
      #62.5 clk0 = 1'b0;
    end
    // clock stands still between windows; data no longer holds its value
    cad0 = ~cad0;
    cad1 = ~cad1;
  endtask : send_window
endmodule : lrcf_peer
`default_nettype wire

/* File: sim/tb_top.sv */
/*
  testbench of the link receive clocking block: registers, rates, resets, link traffic.
  assumes the peer model and the design sources.
*/
`timescale 1ns/10ps
`default_nettype none
`include "lrcf_regs.svh"
module tb_top;
  logic                 clk;
  logic                 rst_b;
  logic                 pg;
  logic                 stop_n;
  lrcf_pkg::lrcf_mode_t mode;
  lrcf_pkg::lrcf_bus_t  bus;
  wire logic [1:0]      lclk;
  wire logic [15:0]     lcad;
  logic [31:0]          rdata;
  logic                 tx_clk;
  logic [15:0]          rx_data;
  logic                 rx_valid;
  logic [4:0]           unit;
  int                   mismatches;
  int                   total_checks;
  int                   rx_n;
  logic                 rx_on;

  lrcf_top i_lrcf_top (
    .sys_clk_in           (clk),
    .rst_b_in             (rst_b),
    .power_good_in        (pg),
    .link_stop_n_in       (stop_n),
    .link_clk_in          (lclk),
    .link_cad_in          (lcad),
    .clk_mode_in          (mode),
    .bus_in               (bus),
    .bus_rdata_out        (rdata),
    .tx_clk_out           (tx_clk),
    .rx_data_out          (rx_data),
    .rx_valid_out         (rx_valid),
    .node_unit_number_out (unit)
  );

  lrcf_peer i_lrcf_peer (
    .link_clk_out (lclk),
    .link_cad_out (lcad)
  );

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task end_of_test;
    if (mismatches == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_of_test

  task do_reset(input logic cold, input lrcf_pkg::lrcf_mode_t m);
    @(posedge clk);
    rst_b <= 1'b0;
    pg    <= ~cold;
    mode  <= m;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    pg    <= 1'b1;
  endtask : do_reset

  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= '0;
  endtask : wr

  task rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge clk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus <= '0;
    #1;
    check(rdata & m, e);
  endtask : rd

  task stop_pulse;
    @(posedge clk);
    stop_n <= 1'b0;
    repeat (8) @(posedge clk);
    stop_n <= 1'b1;
    repeat (8) @(posedge clk);
  endtask : stop_pulse

  // cycles between two rising edges of the transmit clock
  task tx_period(input logic [7:0] e);
    int         r;
    logic       p;
    logic [7:0] n;
    r = 0;
    n = 8'h00;
    p = 1'b1;
    for (int k = 0; k < 100 && r < 2; k++)
    begin
      @(posedge clk);
      #1;
      n = n + 8'h01;
      if (tx_clk === 1'b1 && p === 1'b0)
      begin
        r++;
        if (r == 1)
          n = 8'h00;
      end
      p = tx_clk;
    end
    check(r, 2);
    if (r < 2)
      end_of_test();
    check(n, e);
  endtask : tx_period

  task window(input int base, input logic bad, input logic on);
    rx_n  = base;
    rx_on = on;
    i_lrcf_peer.send_window(base, bad);
    repeat (200) @(posedge clk);
    rx_on = 1'b0;
  endtask : window

  // words leave in stream order, one per valid pulse
  always @(negedge clk)
    if (rx_on && rx_valid === 1'b1)
    begin
      check(rx_data, i_lrcf_peer.word(rx_n));
      rx_n++;
    end

  initial
  begin
    rst_b        = 1'b0;
    pg           = 1'b0;
    stop_n       = 1'b1;
    mode         = lrcf_pkg::LRCF_MODE_SYNC;
    bus          = '0;
    rx_on        = 1'b0;
    rx_n         = 0;
    mismatches   = 0;
    total_checks = 0;
    do_reset(1'b1, lrcf_pkg::LRCF_MODE_SYNC);
    rd(`LRCF_OFF_RATE, 32'hff, 32'h00);
    rd(`LRCF_OFF_STATUS, 32'h07, 32'h00);
    tx_period(8'd16);
    wr(`LRCF_OFF_UNIT, 32'h05);
    rd(`LRCF_OFF_UNIT, 32'h1f, 32'h05);
    check(unit, 32'h05);
    rd(4'h2, 32'hffffffff, 32'h00);
    wr(`LRCF_OFF_RATE, 32'h02);
    rd(`LRCF_OFF_RATE, 32'hff, 32'h02);
    tx_period(8'd16);
    stop_pulse();
    rd(`LRCF_OFF_RATE, 32'hff, 32'h22);
    tx_period(8'd12);
    do_reset(1'b0, lrcf_pkg::LRCF_MODE_ASYNC);
    tx_period(8'd12);
    do_reset(1'b0, lrcf_pkg::LRCF_MODE_ARB);
    tx_period(8'd16);
    do_reset(1'b0, lrcf_pkg::LRCF_MODE_PSEUDO);
    rd(`LRCF_OFF_RATE, 32'hff, 32'h22);
    check(unit, 32'h00);
    wr(`LRCF_OFF_PEER, 32'h01);
    tx_period(8'd14);
    window(0, 1'b0, 1'b1);
    check(rx_n, 512);
    rd(`LRCF_OFF_STATUS, 32'h07, 32'h00);
    window(512, 1'b1, 1'b1);
    check(rx_n, 1024);
    rd(`LRCF_OFF_STATUS, 32'h01, 32'h01);
    do_reset(1'b0, lrcf_pkg::LRCF_MODE_PSEUDO);
    rd(`LRCF_OFF_STATUS, 32'h01, 32'h01);
    do_reset(1'b1, lrcf_pkg::LRCF_MODE_SYNC);
    rd(`LRCF_OFF_STATUS, 32'h07, 32'h00);
    rd(`LRCF_OFF_RATE, 32'hff, 32'h00);
    window(0, 1'b0, 1'b0);
    rd(`LRCF_OFF_STATUS, 32'h02, 32'h02);
    wr(`LRCF_OFF_RATE, 32'h06);
    stop_pulse();
    wr(`LRCF_OFF_STATUS, 32'h07);
    window(0, 1'b0, 1'b0);
    rd(`LRCF_OFF_STATUS, 32'h04, 32'h04);
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
